//--- rtl/psdb_bridge.sv
// Parallel host port to serial debug link bridge.
`timescale 1ns/1ps
module psdb_bridge
	import psdb_pkg::*;
(
	// System clock and reset.
	input  wire logic              clock,
	input  wire logic              rstn,
	// Link clock that times the serial side.
	input  wire logic              link_clock,
	// Host parallel port.
	input  wire logic              cable_absent,
	input  wire logic [ADDR_W-1:0] host_addr,
	input  wire logic [ADDR_W-1:0] board_address_switch,
	input  wire logic              host_reg_sel,
	input  wire logic              host_wr_n,
	input  wire logic              host_rd_n,
	input  wire logic [DATA_W-1:0] host_data_in,
	output logic      [DATA_W-1:0] host_data_out,
	output logic                   host_data_oe,
	output logic                   host_request_line,
	// Target status pins.
	input  wire logic              target_soft_reset_n,
	input  wire logic              target_hard_reset_n,
	input  wire logic [1:0]        target_freeze,
	// Serial debug link.
	output logic                   serial_debug_clock,
	output logic                   serial_debug_clock_oe,
	output logic                   serial_to_target,
	output logic                   serial_to_target_oe,
	input  wire logic              serial_from_target
);
	// Synchronised host side pins.
	localparam int SW = 1 + 2 * ADDR_W + 3 + DATA_W + 4 + 1;
	localparam logic [SW-1:0] S_RST = {1'b1, {(2 * ADDR_W){1'b0}}, 3'h3,
		{DATA_W{1'b0}}, 4'hC, 1'b0};
	logic                  cable_absent_s;
	logic [ADDR_W-1:0]     addr_s;
	logic [ADDR_W-1:0]     switch_s;
	logic                  sel_s;
	logic                  wr_n_s;
	logic                  rd_n_s;
	logic [DATA_W-1:0]     din_s;
	logic                  sreset_n_s;
	logic                  hreset_n_s;
	logic [1:0]            freeze_s;
	logic                  ack_tgl_s;

	// System domain state.
	logic                  wr_n_d_r;
	logic                  rd_n_d_r;
	logic [CTRL_W-1:0]     ctrl_r;
	logic [CTRL_W-1:0]     ctrl_nxt;
	logic [DATA_W-1:0]     tx_hold_r;
	logic [DATA_W-1:0]     tx_hold_nxt;
	logic [DATA_W-1:0]     rx_r;
	logic [DATA_W-1:0]     rx_nxt;
	logic                  cut_r;
	logic                  cut_nxt;
	logic                  busy_r;
	logic                  busy_nxt;
	logic                  req_tgl_r;
	logic                  req_tgl_nxt;
	logic                  ack_seen_r;
	logic                  ack_seen_nxt;
	logic                  pend_r;
	logic                  pend_nxt;
	logic                  tgt_rst_d_r;
	logic [DATA_W-1:0]     dout_nxt;

	// Decoded host events.
	logic                  addressed;
	logic                  wr_ev;
	logic                  rd_ev;
	logic                  tgt_rst;
	logic                  ack_ev;
	logic [DATA_W-1:0]     csr_val;

	// Link domain state.
	typedef enum logic [5:0] {
		L_IDLE  = 6'h01,
		L_READY = 6'h02,
		L_LOW   = 6'h04,
		L_HIGH  = 6'h08,
		L_TAIL  = 6'h10,
		L_DONE  = 6'h20
	} psdb_lstate_t;
	psdb_lstate_t          lst_r;
	psdb_lstate_t          lst_nxt;
	logic [2:0]            bit_r;
	logic [2:0]            bit_nxt;
	logic [DATA_W-1:0]     sh_r;
	logic [DATA_W-1:0]     sh_nxt;
	logic                  lcut_r;
	logic                  lcut_nxt;
	logic                  ack_tgl_r;
	logic                  ack_tgl_nxt;
	logic                  req_seen_r;
	logic                  req_seen_nxt;
	logic                  sck_r;
	logic                  sck_nxt;
	logic                  sdi_r;
	logic                  sdi_nxt;

	// Synchronised link side levels.
	logic                  req_tgl_ls;
	logic [CTRL_W-1:0]     ctrl_ls;
	logic                  tgt_rst_ls;
	logic                  from_tgt_ls;
	logic                  cable_absent_ls;
	logic                  rx_bit;

	// Every host pin passes two stages before any logic reads it.
	psdb_sync #(.W(SW), .RST_VAL(S_RST)) u_sync_sys (
		.clock (clock),
		.rstn  (rstn),
		.d     ({cable_absent, host_addr, board_address_switch, host_reg_sel,
			host_wr_n, host_rd_n, host_data_in, target_soft_reset_n,
			target_hard_reset_n, target_freeze, ack_tgl_r}),
		.q     ({cable_absent_s, addr_s, switch_s, sel_s, wr_n_s, rd_n_s,
			din_s, sreset_n_s, hreset_n_s, freeze_s, ack_tgl_s})
	);

	// Levels crossing into the link domain.
	psdb_sync #(.W(CTRL_W + 4), .RST_VAL({1'b0, CTRL_RESET, 3'h1})) u_sync_link (
		.clock (link_clock),
		.rstn  (rstn),
		.d     ({req_tgl_r, ctrl_r, tgt_rst, serial_from_target, cable_absent}),
		.q     ({req_tgl_ls, ctrl_ls, tgt_rst_ls, from_tgt_ls, cable_absent_ls})
	);

	// Strobes act on their falling edge, only for this board's address.
	assign addressed = !cable_absent_s && (addr_s == switch_s);
	assign wr_ev = addressed && wr_n_d_r && !wr_n_s;
	assign rd_ev = addressed && rd_n_d_r && !rd_n_s;
	assign tgt_rst = !sreset_n_s || !hreset_n_s;
	assign ack_ev = ack_tgl_s != ack_seen_r;

	// Status in the top bits, control in the low bits.
	always_comb begin
		csr_val = '0;
		csr_val[CSR_RESET_BIT] = tgt_rst;
		csr_val[CSR_CUT_BIT] = cut_r;
		csr_val[CSR_HALT_BIT] = &freeze_s;
		csr_val[CSR_POLL_BIT+2-:2] = CSR_RSVD_VAL;
		csr_val[CTRL_W-1:0] = ctrl_r;
	end

	// Host register access and the exchange request toward the link.
	always_comb begin
		ctrl_nxt = ctrl_r;
		tx_hold_nxt = tx_hold_r;
		rx_nxt = rx_r;
		cut_nxt = cut_r;
		busy_nxt = busy_r;
		req_tgl_nxt = req_tgl_r;
		ack_seen_nxt = ack_tgl_s;
		pend_nxt = pend_r;
		// A status read clears the poll request; a new event below still wins.
		if (rd_ev && sel_s == SEL_CSR) begin
			pend_nxt = 1'b0;
		end
		// Only the control bits are writable; status and reserved bits ignore writes.
		if (wr_ev && sel_s == SEL_CSR) begin
			ctrl_nxt = din_s[CTRL_W-1:0];
		end
		// A write while an exchange runs is dropped so the shifter never sees a torn byte.
		if (wr_ev && sel_s == SEL_DATA && !busy_r) begin
			tx_hold_nxt = din_s;
			req_tgl_nxt = !req_tgl_r;
			busy_nxt = 1'b1;
		end
		// The link result is stable once the acknowledge toggle has crossed.
		if (ack_ev) begin
			rx_nxt = sh_r;
			cut_nxt = lcut_r;
			busy_nxt = 1'b0;
			pend_nxt = 1'b1;
		end
		if (tgt_rst && !tgt_rst_d_r) begin
			pend_nxt = 1'b1;
		end
		// Pulling the cable restores the wake-up control values.
		if (cable_absent_s) begin
			ctrl_nxt = CTRL_RESET;
			pend_nxt = 1'b0;
		end
	end

	// Read data is registered every cycle from the selected register.
	always_comb begin
		dout_nxt = (sel_s == SEL_DATA) ? rx_r : csr_val;
	end

	// System domain registers.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_n_d_r <= 1'b1;
			rd_n_d_r <= 1'b1;
			ctrl_r <= CTRL_RESET;
			tx_hold_r <= '0;
			rx_r <= '0;
			cut_r <= 1'b0;
			busy_r <= 1'b0;
			req_tgl_r <= 1'b0;
			ack_seen_r <= 1'b0;
			pend_r <= 1'b0;
			tgt_rst_d_r <= 1'b0;
			host_data_out <= '0;
		end else begin
			wr_n_d_r <= wr_n_s;
			rd_n_d_r <= rd_n_s;
			ctrl_r <= ctrl_nxt;
			tx_hold_r <= tx_hold_nxt;
			rx_r <= rx_nxt;
			cut_r <= cut_nxt;
			busy_r <= busy_nxt;
			req_tgl_r <= req_tgl_nxt;
			ack_seen_r <= ack_seen_nxt;
			pend_r <= pend_nxt;
			tgt_rst_d_r <= tgt_rst;
			host_data_out <= dout_nxt;
		end
	end

	// Drive the host bus only while this board is addressed and read.
	assign host_data_oe = addressed && !rd_n_s;
	// Poll request shows pending news while its active-low enable is set.
	assign host_request_line = pend_r && !ctrl_r[CSR_POLL_BIT];

	// In loopback the transmitted bit is caught back instead of the target line.
	assign rx_bit = ctrl_ls[CSR_LOOP_BIT] ? from_tgt_ls : sdi_r;

	// Link sequencer: wait ready, then eight full-duplex clock periods.
	always_comb begin
		lst_nxt = lst_r;
		bit_nxt = bit_r;
		sh_nxt = sh_r;
		lcut_nxt = lcut_r;
		ack_tgl_nxt = ack_tgl_r;
		req_seen_nxt = req_seen_r;
		sck_nxt = 1'b0;
		sdi_nxt = sdi_r;
		case (lst_r)
			L_IDLE: begin
				// While the target sits in reset the data-in line carries debug entry.
				sdi_nxt = !ctrl_ls[CSR_ENTRY_BIT];
				if (req_tgl_ls != req_seen_r) begin
					req_seen_nxt = req_tgl_ls;
					sh_nxt = tx_hold_r;
					lcut_nxt = 1'b0;
					bit_nxt = '0;
					lst_nxt = L_READY;
				end
			end
			L_READY: begin
				// Loopback has no target to wait for.
				if (!ctrl_ls[CSR_LOOP_BIT] ||
					from_tgt_ls == TARGET_READY_LVL) begin
					lst_nxt = L_LOW;
				end
			end
			L_LOW: begin
				// Data is set up a clock before the rising edge, most significant bit first.
				sdi_nxt = sh_r[DATA_W-1];
				lst_nxt = L_HIGH;
			end
			L_HIGH: begin
				// Loopback catches the bit just placed; the target line arrives a bit late.
				sck_nxt = 1'b1;
				sh_nxt = {sh_r[DATA_W-2:0], rx_bit};
				bit_nxt = bit_r + 3'h1;
				lst_nxt = (bit_r == 3'(BITS_PER_BYTE - 1)) ? L_TAIL : L_LOW;
			end
			L_TAIL: begin
				// One more clock lets the last target bit clear the synchroniser.
				lst_nxt = L_DONE;
			end
			L_DONE: begin
				// The synchroniser delays the target line by one bit, so its last bit lands here.
				if (ctrl_ls[CSR_LOOP_BIT]) begin
					sh_nxt = {sh_r[DATA_W-2:0], from_tgt_ls};
				end
				ack_tgl_nxt = !ack_tgl_r;
				lst_nxt = L_IDLE;
			end
			default: begin
				lst_nxt = L_IDLE;
			end
		endcase
		// A target reset in mid byte ends the exchange and marks it cut.
		if (tgt_rst_ls && (lst_r == L_LOW || lst_r == L_HIGH)) begin
			lcut_nxt = 1'b1;
			sck_nxt = 1'b0;
			lst_nxt = L_DONE;
		end
	end

	// Link domain registers.
	always_ff @(posedge link_clock or negedge rstn) begin
		if (!rstn) begin
			lst_r <= L_IDLE;
			bit_r <= '0;
			sh_r <= '0;
			lcut_r <= 1'b0;
			ack_tgl_r <= 1'b0;
			req_seen_r <= 1'b0;
			sck_r <= 1'b0;
			sdi_r <= 1'b1;
		end else begin
			lst_r <= lst_nxt;
			bit_r <= bit_nxt;
			sh_r <= sh_nxt;
			lcut_r <= lcut_nxt;
			ack_tgl_r <= ack_tgl_nxt;
			req_seen_r <= req_seen_nxt;
			sck_r <= sck_nxt;
			sdi_r <= sdi_nxt;
		end
	end

	// Serial pins come from link flops and are released without the cable.
	assign serial_debug_clock = sck_r;
	assign serial_debug_clock_oe = !cable_absent_ls;
	assign serial_to_target = sdi_r;
	assign serial_to_target_oe = !cable_absent_ls && ctrl_ls[CSR_LOOP_BIT];
endmodule

//--- include/psdb_pkg.sv
// Constants shared by the parallel to serial debug bridge.
// Notes on behaviour
// - Host side is an eight bit parallel port that writes and reads bytes.
// - Hardware serialises host bytes and deserialises received bits with no software help.
// - Bridge generates the serial debug clock itself, unrelated to the target clock.
// - With the host cable absent the bridge is disabled and releases the serial lines.
// - Up to eight boards share a bundle; answer only the address on the switch.
// - Exactly two host registers: control/status and data.
// - Data register is the parallel face of the transmit/receive shift register.
// - Register select low reaches control/status, high reaches the data register.
// - Control/status register is eight bits, bit 7 most significant.
// - Bit 7 reads high while the target drives soft or hard reset.
// - Bit 6 reads high when the last byte sent was cut by target reset.
// - Bit 5 reads high while the target reports debug mode.
// - Bit 2 low (reset value) enables the poll request to the host.
// - Bit 1 low (reset value) selects loopback; the data-in pin is released.
// - Bit 0 low (reset value) makes the target halt right after soft reset.
// - Exchange is full duplex; wait for target ready on its data-out line first.
package psdb_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 3;
	localparam int CTRL_W = 3;
	localparam int BITS_PER_BYTE = 8;
	// Status and control field positions in the control/status register.
	localparam int CSR_RESET_BIT = 7;
	localparam int CSR_CUT_BIT = 6;
	localparam int CSR_HALT_BIT = 5;
	localparam int CSR_POLL_BIT = 2;
	localparam int CSR_LOOP_BIT = 1;
	localparam int CSR_ENTRY_BIT = 0;
	// All three control bits are active low and wake up active.
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [1:0] CSR_RSVD_VAL = 2'h0;
	// Register select levels.
	localparam logic SEL_CSR = 1'b0;
	localparam logic SEL_DATA = 1'b1;
	// Target data-out level that means ready for a command.
	localparam logic TARGET_READY_LVL = 1'b0;
	// Link clock cycles per serial clock half period.
	localparam int HALF_CYCLES = 1;
	localparam int SYNC_STAGES = 2;
endpackage

//--- rtl/psdb_sync.sv
// Two stage level synchroniser used for every pin and for the toggle and control crossings.
`timescale 1ns/1ps
module psdb_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset of the receiving domain.
	input  wire logic         clock,
	input  wire logic         rstn,
	// Level in and synchronised level out.
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_nxt;

	// The first stage feeds only the second stage.
	always_comb begin
		meta_nxt = d;
		q_nxt = meta_r;
	end

	// Both stages reset to the idle level of the signal.
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_r <= meta_nxt;
			q <= q_nxt;
		end
	end
endmodule

//--- test/psdb_bridge_chk.sv
// Port assertions for the parallel to serial debug bridge.
`timescale 1ns/1ps
module psdb_chk
	import psdb_pkg::*;
(
	// Clocks and reset.
	input wire logic              clock,
	input wire logic              rstn,
	input wire logic              link_clock,
	// Host port.
	input wire logic              cable_absent,
	input wire logic [ADDR_W-1:0] host_addr,
	input wire logic [ADDR_W-1:0] board_address_switch,
	input wire logic              host_reg_sel,
	input wire logic              host_rd_n,
	input wire logic [DATA_W-1:0] host_data_out,
	input wire logic              host_data_oe,
	// Target pins and serial link.
	input wire logic              target_soft_reset_n,
	input wire logic              target_hard_reset_n,
	input wire logic [1:0]        target_freeze,
	input wire logic              serial_debug_clock,
	input wire logic              serial_debug_clock_oe,
	input wire logic              serial_to_target,
	input wire logic              serial_to_target_oe
);
	// Six steady cycles let a pin pass its synchroniser into the register.
	sequence in_reset6;
		(!host_reg_sel && !(target_soft_reset_n && target_hard_reset_n))[*6];
	endsequence
	sequence halted6;
		(!host_reg_sel && target_freeze == 2'h3)[*6];
	endsequence
	sequence absent16;
		cable_absent[*8] ##1 cable_absent[*8];
	endsequence
	a_oe_after_rd: assert property (@(posedge clock) disable iff (!rstn)
		$rose(host_data_oe) |-> !$past(host_rd_n, 2)) else $error("read drive without strobe");
	a_oe_addr_match: assert property (@(posedge clock) disable iff (!rstn)
		$rose(host_data_oe) |-> !$past(cable_absent, 2)
		&& $past(host_addr, 2) == $past(board_address_switch, 2)) else $error("foreign read");
	a_link_release: assert property (@(posedge clock) disable iff (!rstn)
		absent16 |-> !serial_debug_clock_oe && !serial_to_target_oe) else $error("link held");
	a_data_steady: assert property (@(posedge link_clock) disable iff (!rstn)
		serial_debug_clock |-> $stable(serial_to_target)) else $error("data moved at clock");
	a_clock_pulse: assert property (@(posedge link_clock) disable iff (!rstn)
		serial_debug_clock |=> !serial_debug_clock) else $error("serial clock too long");
	a_stat_reset: assert property (@(posedge clock) disable iff (!rstn)
		in_reset6 |-> host_data_out[CSR_RESET_BIT]) else $error("reset flag low");
	a_stat_halt: assert property (@(posedge clock) disable iff (!rstn)
		halted6 |-> host_data_out[CSR_HALT_BIT]) else $error("halt flag low");
	a_rsvd_zero: assert property (@(posedge clock) disable iff (!rstn)
		(!host_reg_sel)[*6] |-> host_data_out[4:3] == CSR_RSVD_VAL) else $error("reserved set");
endmodule
bind psdb_bridge psdb_chk u_chk (.clock, .rstn, .link_clock, .cable_absent, .host_addr,
	.board_address_switch, .host_reg_sel, .host_rd_n, .host_data_out, .host_data_oe,
	.target_soft_reset_n, .target_hard_reset_n, .target_freeze, .serial_debug_clock,
	.serial_debug_clock_oe, .serial_to_target, .serial_to_target_oe);

//--- test/psdb_target.sv
// Behavioural target end of the serial debug link.
`timescale 1ns/1ps
module psdb_target
	import psdb_pkg::*;
(
	// Serial link seen from the target.
	input  wire logic              serial_debug_clock,
	input  wire logic              serial_to_target,
	output logic                   serial_from_target,
	// Byte to answer with and byte last taken in.
	input  wire logic [DATA_W-1:0] reply,
	output logic      [DATA_W-1:0] got
);
	logic [DATA_W-1:0] rx = '0;
	int                cnt = 0;
	// Idle low doubles as ready, so a reply must begin with a low bit.
	initial serial_from_target = TARGET_READY_LVL;
	initial got = '0;
	// Take a bit on each rising serial clock edge, most significant first.
	always @(posedge serial_debug_clock) begin
		rx = {rx[DATA_W-2:0], serial_to_target};
		cnt = cnt + 1;
	end
	// Shift the reply out in step with the incoming bits.
	always @(negedge serial_debug_clock) begin
		if (cnt == BITS_PER_BYTE) begin
			got = rx;
			cnt = 0;
			serial_from_target = TARGET_READY_LVL;
		end else begin
			serial_from_target = reply[DATA_W-1-cnt];
		end
	end
endmodule

//--- test/test_parallel_serial_debug_bridge.sv
// Self-checking bench for the parallel to serial debug bridge.
`timescale 1ns/1ps
module test_parallel_serial_debug_bridge
	import psdb_pkg::*;
;
	logic              clock = 0, rstn = 0, link_clock = 0, cable_absent = 0;
	logic              host_reg_sel = 0, host_wr_n = 1, host_rd_n = 1, rd_oe;
	logic [ADDR_W-1:0] host_addr = 3'h2, board_address_switch = 3'h2;
	logic [DATA_W-1:0] host_data_in = 8'h00, host_data_out, reply = 8'h5A, got, rd_val;
	logic              host_data_oe, host_request_line, serial_debug_clock;
	logic              serial_debug_clock_oe, serial_to_target, serial_to_target_oe;
	logic              serial_from_target, target_soft_reset_n = 1, target_hard_reset_n = 1;
	logic [1:0]        target_freeze = 2'h0;
	int                err_total = 0, n_tests = 0;
	// System clock at 200 MHz; the link clock runs at 12 ns with its own phase.
	always #2.5 clock = ~clock;
	initial #1.3 forever #6 link_clock = ~link_clock;
	psdb_bridge dut (.clock, .rstn, .link_clock, .cable_absent, .host_addr,
		.board_address_switch, .host_reg_sel, .host_wr_n, .host_rd_n, .host_data_in,
		.host_data_out, .host_data_oe, .host_request_line, .target_soft_reset_n,
		.target_hard_reset_n, .target_freeze, .serial_debug_clock, .serial_debug_clock_oe,
		.serial_to_target, .serial_to_target_oe, .serial_from_target);
	psdb_target u_target (.serial_debug_clock, .serial_to_target, .serial_from_target,
		.reply, .got);
	// Compare and count; unknowns never match.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		$display("Comparisons %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Write strobes stay four cycles each way, read strobes six low and five high, above the three the synchronisers need.
	task automatic host_wr(input logic sel, input logic [7:0] d);
		@(negedge clock);
		host_reg_sel = sel;
		host_data_in = d;
		@(negedge clock);
		host_wr_n = 0;
		repeat (4) @(negedge clock);
		host_wr_n = 1;
		repeat (4) @(negedge clock);
	endtask
	task automatic host_rd(input logic sel, output logic [7:0] d, output logic oe);
		@(negedge clock);
		host_reg_sel = sel;
		host_rd_n = 0;
		repeat (6) @(negedge clock);
		d = host_data_out;
		oe = host_data_oe;
		host_rd_n = 1;
		repeat (5) @(negedge clock);
	endtask
	task automatic wait_req;
		int i;
		for (i = 0; i < 400 && host_request_line !== 1'b1; i++)
			@(negedge clock);
		if (host_request_line !== 1'b1) begin
			err_total++;
			$display("CHECK FAILED at %0t: no poll request", $time);
			results();
		end
	endtask
	task automatic t_reset;
		host_rd(SEL_CSR, rd_val, rd_oe);
		check(rd_val, 8'h00);
		check(8'(rd_oe), 8'h01);
		check(8'(serial_to_target_oe), 8'h00);
		check(8'(serial_to_target), 8'h01);
	endtask
	// Loopback exchange must echo the byte and raise the poll request.
	task automatic t_loop;
		host_wr(SEL_DATA, 8'hA5);
		wait_req();
		host_rd(SEL_DATA, rd_val, rd_oe);
		check(rd_val, 8'hA5);
		host_rd(SEL_CSR, rd_val, rd_oe);
		check(rd_val, 8'h00);
		check(8'(host_request_line), 8'h00);
	endtask
	task automatic t_normal;
		host_wr(SEL_CSR, 8'h06);
		check(8'(serial_to_target_oe), 8'h01);
		host_wr(SEL_DATA, 8'h3C);
		repeat (120) @(negedge clock);
		check(8'(host_request_line), 8'h00);
		check(got, 8'h3C);
		host_rd(SEL_DATA, rd_val, rd_oe);
		check(rd_val, 8'h5A);
	endtask
	// Pins soft, hard, freeze per row; upper control bits written are dropped.
	task automatic t_status;
		logic [3:0] pins[4] = '{4'h4, 4'h8, 4'hF, 4'hD};
		logic [7:0] expv[4] = '{8'h86, 8'h86, 8'h26, 8'h06};
		host_wr(SEL_CSR, 8'hFE);
		for (int i = 0; i < 4; i++) begin
			{target_soft_reset_n, target_hard_reset_n, target_freeze} = pins[i];
			host_rd(SEL_CSR, rd_val, rd_oe);
			check(rd_val, expv[i]);
		end
		{target_soft_reset_n, target_hard_reset_n, target_freeze} = 4'hC;
	endtask
	task automatic t_addr;
		host_addr = 3'h5;
		host_rd(SEL_CSR, rd_val, rd_oe);
		check(8'(rd_oe), 8'h00);
		host_wr(SEL_CSR, 8'h00);
		host_addr = 3'h2;
		host_rd(SEL_CSR, rd_val, rd_oe);
		check(rd_val, 8'h06);
	endtask
	task automatic t_cable;
		cable_absent = 1;
		repeat (20) @(negedge clock);
		check(8'({serial_debug_clock_oe, serial_to_target_oe}), 8'h00);
		host_rd(SEL_CSR, rd_val, rd_oe);
		check(8'(rd_oe), 8'h00);
		cable_absent = 0;
		repeat (10) @(negedge clock);
		host_rd(SEL_CSR, rd_val, rd_oe);
		check(rd_val, 8'h00);
	endtask
	// Reset for eight cycles, then run every scenario in turn.
	initial begin
		repeat (8) @(negedge clock);
		rstn = 1;
		repeat (6) @(negedge clock);
		t_reset();
		t_loop();
		t_normal();
		t_status();
		t_addr();
		t_cable();
		results();
	end
endmodule
